// File: verilog/trig_gen_consts.vh
// Purpose: Constants for the timer conversion-start trigger generator
// Assumes: 32-bit register port, word offsets
// Notes:   Offsets, fields and reset values only
`ifndef TRIG_GEN_CONSTS_VH
`define TRIG_GEN_CONSTS_VH

// ==========================================================
// Register offsets
`define OFS_DIR_EN      8'h00
`define OFS_STATUS      8'h04
`define OFS_IRQ_STAT    8'h08
`define OFS_IRQ_MASK    8'h0C
`define OFS_BUF_CFG     8'h10
`define OFS_MON_CFG     8'h14
`define OFS_CMP_A       8'h18
`define OFS_BUF_A       8'h1C
`define OFS_BUF2_A      8'h20
`define OFS_CMP_B       8'h24
`define OFS_BUF_B       8'h28
`define OFS_BUF2_B      8'h2C

// ==========================================================
// Event bit positions (enables, status, irq)
`define EV_A_UP         0
`define EV_A_DOWN       1
`define EV_B_UP         2
`define EV_B_DOWN       3
`define EV_W            4

// ==========================================================
// Buffer configuration fields
`define BUF_DISABLE     0
`define BUF_A_DOUBLE    1
`define BUF_B_DOUBLE    2
`define BUF_TT_A_LSB    4
`define BUF_TT_B_LSB    6

// ==========================================================
// Monitor configuration fields
`define MON0_SEL_LSB    0
`define MON0_EN         2
`define MON1_SEL_LSB    4
`define MON1_EN         6

// ==========================================================
// Transfer timing codes
`define TT_NONE         2'h0
`define TT_ONE          2'h1
`define TT_TWO          2'h2
`define TT_BOTH         2'h3

// ==========================================================
// Reset values
`define RST_DIR_EN      4'h0
`define RST_BUF_CFG     8'h00
`define RST_MON_CFG     7'h00
`define RST_IRQ_MASK    4'h0

`endif

// File: verilog/pwm_timer_adc_trigger_gen.v
// Purpose: Conversion-start trigger generator beside a PWM period counter
// Assumes: Counter, direction and wave events come from the timer, one clock
// Notes:   Trigger pulses leave through the event link toward the converter
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
`include "trig_gen_consts.vh"

// Operation
// RULE1: Request A on counter equal compare A, B on compare B, if direction enabled.
// RULE2: Counts 0..period-1 form up interval, period..1 form down interval.
// RULE3: Four direction enables, same meaning in triangle and sawtooth modes.
// RULE4: During event count operation no requests, enables ignored.
// RULE5: Request A sets down flag in down interval, up flag in up interval.
// RULE6: Software clears a flag by writing 0; stays zero until next request.
// RULE7: Buffer disable bit set stops all transfers into both compare registers.
// RULE8: Per register select: 0 single buffer, 1 double buffer chain.
// RULE9: Double buffer moves second to first and first to compare together.
// RULE10: Triangle modes timing: 00 none, 01 crest, 10 trough, 11 both.
// RULE11: Sawtooth modes: 00 none, 01 underflow, 10 overflow, 11 counter clear.
// RULE12: Monitor output rises on selected request, falls at end of cycle.
// RULE13: Monitor source: 00 A up, 01 A down, 10 B up, 11 B down.
// RULE14: Counter stopped, monitor outputs hold their level.
// RULE15: Monitor enable bit zero drives that output low.
// RULE16: Request at end of cycle wins, output stays high another cycle.
// RULE17: Monitor pin carries OR of all channels enabling it.
// RULE18: Requests go to the converter as event link start events.
// RULE19: Each request is a one-cycle pulse per qualifying match.
module pwm_timer_adc_trigger_gen #(
	parameter CW = 16
) (
	// Clock and reset
	input  wire          i_clk,
	input  wire          i_rst_n,
	// Register port
	input  wire [7:0]    i_addr,
	input  wire [31:0]   i_wdata,
	input  wire          i_wr,
	input  wire          i_rd,
	output reg  [31:0]   o_rdata,
	// Timer side
	input  wire [CW-1:0] i_period_counter,
	input  wire [CW-1:0] i_period_setting,
	input  wire          i_count_step,
	input  wire          i_count_up,
	input  wire          i_event_count,
	input  wire          i_sawtooth,
	input  wire          i_crest,
	input  wire          i_trough,
	input  wire          i_underflow,
	input  wire          i_overflow,
	input  wire          i_counter_clear,
	input  wire          i_cycle_end,
	// Monitor signals of other channels
	input  wire [1:0]    i_monitor_chain,
	// Trigger requests to the event link
	output reg           o_trig_a,
	output reg           o_trig_b,
	// Monitor pins and interrupt
	output reg  [1:0]    o_trigger_monitor_pin,
	output reg           o_irq
);

// ==========================================================
// Decode functions

// RULE10 crest trough
// RULE11 sawtooth points
function xfer_hit;
	input [1:0] tt;
	input       saw;
	input       crest;
	input       trough;
	input       under;
	input       over;
	input       clr;
	begin
		case (tt)
			`TT_ONE:  xfer_hit = saw ? under : crest;
			`TT_TWO:  xfer_hit = saw ? over : trough;
			`TT_BOTH: xfer_hit = saw ? clr : (crest | trough);
			default:  xfer_hit = 1'b0;
		endcase
	end
endfunction

// RULE13 source select
function mon_src;
	input [1:0]       sel;
	input [`EV_W-1:0] ev;
	begin
		case (sel)
			2'h0:    mon_src = ev[`EV_A_UP];
			2'h1:    mon_src = ev[`EV_A_DOWN];
			2'h2:    mon_src = ev[`EV_B_UP];
			2'h3:    mon_src = ev[`EV_B_DOWN];
			default: mon_src = 1'b0;
		endcase
	end
endfunction

// ==========================================================
// Registers

reg [`EV_W-1:0] dir_en;
reg [`EV_W-1:0] status;
reg [`EV_W-1:0] irq_stat;
reg [`EV_W-1:0] irq_mask;
reg [7:0]       buf_cfg;
reg [6:0]       mon_cfg;
reg [CW-1:0]    cmp_a;
reg [CW-1:0]    buf_a;
reg [CW-1:0]    buf2_a;
reg [CW-1:0]    cmp_b;
reg [CW-1:0]    buf_b;
reg [CW-1:0]    buf2_b;
reg [1:0]       mon_state;

wire wr_dir    = i_wr && (i_addr == `OFS_DIR_EN);
wire wr_status = i_wr && (i_addr == `OFS_STATUS);
wire wr_mask   = i_wr && (i_addr == `OFS_IRQ_MASK);
wire wr_buf    = i_wr && (i_addr == `OFS_BUF_CFG);
wire wr_mon    = i_wr && (i_addr == `OFS_MON_CFG);
wire wr_cmp_a  = i_wr && (i_addr == `OFS_CMP_A);
wire wr_buf_a  = i_wr && (i_addr == `OFS_BUF_A);
wire wr_buf2_a = i_wr && (i_addr == `OFS_BUF2_A);
wire wr_cmp_b  = i_wr && (i_addr == `OFS_CMP_B);
wire wr_buf_b  = i_wr && (i_addr == `OFS_BUF_B);
wire wr_buf2_b = i_wr && (i_addr == `OFS_BUF2_B);
wire rd_irq    = i_rd && (i_addr == `OFS_IRQ_STAT);

// ==========================================================
// Interval and match

// RULE2 interval split
// The crest value belongs to the down interval, zero to the up interval.
wire in_up = i_count_up ? (i_period_counter != i_period_setting)
                        : (i_period_counter == {CW{1'b0}});

// RULE1 compare match
// Matching only on a count step keeps one request per counter value.
wire match_a = i_count_step && (i_period_counter == cmp_a);
wire match_b = i_count_step && (i_period_counter == cmp_b);

reg [`EV_W-1:0] ev;

always @*
begin
	ev              = {`EV_W{1'b0}};
	ev[`EV_A_UP]    = match_a & in_up;
	ev[`EV_A_DOWN]  = match_a & ~in_up;
	ev[`EV_B_UP]    = match_b & in_up;
	ev[`EV_B_DOWN]  = match_b & ~in_up;
	// RULE3 direction enables
	ev              = ev & dir_en;
	// RULE4 event count blocks
	if (i_event_count)
		ev = {`EV_W{1'b0}};
end

// ==========================================================
// Buffer transfer

// RULE7 disable blocks all
wire buf_on = ~buf_cfg[`BUF_DISABLE];
wire xfer_a = buf_on & xfer_hit(buf_cfg[`BUF_TT_A_LSB +: 2], i_sawtooth, i_crest,
	i_trough, i_underflow, i_overflow, i_counter_clear);
wire xfer_b = buf_on & xfer_hit(buf_cfg[`BUF_TT_B_LSB +: 2], i_sawtooth, i_crest,
	i_trough, i_underflow, i_overflow, i_counter_clear);

always @(posedge i_clk)
begin
	if (!i_rst_n)
	begin
		cmp_a  <= {CW{1'b0}};
		buf_a  <= {CW{1'b0}};
		buf2_a <= {CW{1'b0}};
		cmp_b  <= {CW{1'b0}};
		buf_b  <= {CW{1'b0}};
		buf2_b <= {CW{1'b0}};
	end
	else
	begin
		// A software write to a stage wins over a transfer into it
		if (wr_buf2_a)
			buf2_a <= i_wdata[CW-1:0];
		if (wr_buf2_b)
			buf2_b <= i_wdata[CW-1:0];
		// RULE8 single or double
		// RULE9 chained move
		if (wr_buf_a)
			buf_a <= i_wdata[CW-1:0];
		else if (xfer_a && buf_cfg[`BUF_A_DOUBLE])
			buf_a <= buf2_a;
		if (wr_buf_b)
			buf_b <= i_wdata[CW-1:0];
		else if (xfer_b && buf_cfg[`BUF_B_DOUBLE])
			buf_b <= buf2_b;
		if (wr_cmp_a)
			cmp_a <= i_wdata[CW-1:0];
		else if (xfer_a)
			cmp_a <= buf_a;
		if (wr_cmp_b)
			cmp_b <= i_wdata[CW-1:0];
		else if (xfer_b)
			cmp_b <= buf_b;
	end
end

// ==========================================================
// Control registers and flags

always @(posedge i_clk)
begin
	if (!i_rst_n)
	begin
		dir_en   <= `RST_DIR_EN;
		buf_cfg  <= `RST_BUF_CFG;
		mon_cfg  <= `RST_MON_CFG;
		irq_mask <= `RST_IRQ_MASK;
		status   <= {`EV_W{1'b0}};
		irq_stat <= {`EV_W{1'b0}};
	end
	else
	begin
		if (wr_dir)
			dir_en <= i_wdata[`EV_W-1:0];
		if (wr_buf)
			buf_cfg <= i_wdata[7:0];
		if (wr_mon)
			mon_cfg <= i_wdata[6:0];
		if (wr_mask)
			irq_mask <= i_wdata[`EV_W-1:0];
		// RULE5 direction flags
		// RULE6 write zero clears
		// A request in the clearing cycle keeps its flag set.
		if (wr_status)
			status <= (status & i_wdata[`EV_W-1:0]) | ev;
		else
			status <= status | ev;
		if (rd_irq)
			irq_stat <= ev;
		else
			irq_stat <= irq_stat | ev;
	end
end

// ==========================================================
// Monitor outputs

reg [1:0] next_mon;
reg       src;
integer   k;

always @*
begin
	src      = 1'b0;
	next_mon = mon_state;
	for (k = 0; k < 2; k = k + 1)
	begin
		src = mon_src(mon_cfg[4*k +: 2], ev);
		// RULE15 disabled low
		if (!mon_cfg[4*k+2])
			next_mon[k] = 1'b0;
		// RULE16 rise wins
		else if (src)
			next_mon[k] = 1'b1;
		// RULE12 fall at cycle end
		// RULE14 hold when stopped
		else if (i_cycle_end)
			next_mon[k] = 1'b0;
	end
end

always @(posedge i_clk)
begin
	if (!i_rst_n)
	begin
		mon_state             <= 2'h0;
		o_trigger_monitor_pin <= 2'h0;
	end
	else
	begin
		mon_state             <= next_mon;
		// RULE17 channel OR
		o_trigger_monitor_pin <= next_mon | i_monitor_chain;
	end
end

// ==========================================================
// Trigger pulses and interrupt

always @(posedge i_clk)
begin
	if (!i_rst_n)
	begin
		o_trig_a <= 1'b0;
		o_trig_b <= 1'b0;
		o_irq    <= 1'b0;
	end
	else
	begin
		// RULE18 event link start
		// RULE19 single pulse
		o_trig_a <= ev[`EV_A_UP] | ev[`EV_A_DOWN];
		o_trig_b <= ev[`EV_B_UP] | ev[`EV_B_DOWN];
		o_irq    <= |((rd_irq ? ev : (irq_stat | ev)) & irq_mask);
	end
end

// ==========================================================
// Read port

always @(posedge i_clk)
begin
	if (!i_rst_n)
		o_rdata <= 32'h0;
	else if (i_rd)
	begin
		o_rdata <= 32'h0;
		case (i_addr)
			`OFS_DIR_EN:   o_rdata[`EV_W-1:0] <= dir_en;
			`OFS_STATUS:   o_rdata[`EV_W-1:0] <= status;
			`OFS_IRQ_STAT: o_rdata[`EV_W-1:0] <= irq_stat;
			`OFS_IRQ_MASK: o_rdata[`EV_W-1:0] <= irq_mask;
			`OFS_BUF_CFG:  o_rdata[7:0]       <= buf_cfg;
			`OFS_MON_CFG:  o_rdata[6:0]       <= mon_cfg;
			`OFS_CMP_A:    o_rdata[CW-1:0]    <= cmp_a;
			`OFS_BUF_A:    o_rdata[CW-1:0]    <= buf_a;
			`OFS_BUF2_A:   o_rdata[CW-1:0]    <= buf2_a;
			`OFS_CMP_B:    o_rdata[CW-1:0]    <= cmp_b;
			`OFS_BUF_B:    o_rdata[CW-1:0]    <= buf_b;
			`OFS_BUF2_B:   o_rdata[CW-1:0]    <= buf2_b;
			default:       o_rdata            <= 32'h0;
		endcase
	end
end

endmodule

// File: tb/trig_gen_properties.sv
// Purpose: Port checks of the trigger generator
// Assumes: One clock, synchronous reset
// Notes:   Bound below the module
`timescale 1ns/1ns
module trig_gen_properties (
	input wire        i_clk,
	input wire        i_rst_n,
	input wire        i_wr,
	input wire        i_count_step,
	input wire        i_event_count,
	input wire        i_cycle_end,
	input wire [1:0]  i_monitor_chain,
	input wire        o_trig_a,
	input wire        o_trig_b,
	input wire [1:0]  o_trigger_monitor_pin,
	input wire        o_irq
);
	wire tr = o_trig_a | o_trig_b;
	wire [1:0] pin = o_trigger_monitor_pin;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	// ========
	// Checks
	property p_a_pulse; o_trig_a |=> !o_trig_a; endproperty
	a_a_pulse: assert property (p_a_pulse) else $error("trig a long");
	property p_b_pulse; o_trig_b |=> !o_trig_b; endproperty
	a_b_pulse: assert property (p_b_pulse) else $error("trig b long");
	property p_step; tr |-> $past(i_count_step); endproperty
	a_step: assert property (p_step) else $error("trig no step");
	property p_evc; tr |-> !$past(i_event_count); endproperty
	a_evc: assert property (p_evc) else $error("trig in event count");
	property p_chain; $past(i_rst_n) |-> ($past(i_monitor_chain) & ~pin) == 2'h0; endproperty
	a_chain: assert property (p_chain) else $error("chain lost");
	// Pin and trigger pulse are launched by the same edge
	property p_rise; (pin & ~$past(pin)) != 2'h0 |-> tr || $past(i_wr) || $past(i_wr, 2)
		|| $past(i_monitor_chain) != 2'h0; endproperty
	a_rise: assert property (p_rise) else $error("pin rose alone");
	// Cycle end and a dropped chain input both fall the pin one edge later; the chain's last high value lies two edges back
	property p_fall; ($past(pin) & ~pin) != 2'h0 |-> $past(i_cycle_end) || $past(i_wr)
		|| $past(i_wr, 2) || $past(i_monitor_chain, 2) != 2'h0; endproperty
	a_fall: assert property (p_fall) else $error("pin fell alone");
	property p_irq; $rose(o_irq) |-> tr || $past(i_wr) || $past(i_wr, 2); endproperty
	a_irq: assert property (p_irq) else $error("irq rose alone");
	c_a: cover property (o_trig_a);
	c_b: cover property (o_trig_b);
	c_irq: cover property ($rose(o_irq));
endmodule
bind pwm_timer_adc_trigger_gen trig_gen_properties u_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_wr(i_wr), .i_count_step(i_count_step), .i_event_count(i_event_count),
	.i_cycle_end(i_cycle_end), .i_monitor_chain(i_monitor_chain), .o_trig_a(o_trig_a),
	.o_trig_b(o_trig_b), .o_trigger_monitor_pin(o_trigger_monitor_pin), .o_irq(o_irq));

// File: tb/adc_event_model.sv
// Purpose: Converter behind the event link
// Assumes: Start events arrive as pulses
// Notes:   Counts conversion starts
`timescale 1ns/1ns
module adc_event_model #(
	parameter LAT = 3
) (
	input  wire        i_clk,
	input  wire        i_trig_a,
	input  wire        i_trig_b,
	output reg  [15:0] o_starts
);
	reg [LAT-1:0] dly = 0;
	initial o_starts = 0;
	always @(posedge i_clk)
	begin
		dly <= {dly[LAT-2:0], i_trig_a | i_trig_b};
		if (dly[LAT-1])
			o_starts <= o_starts + 16'h0001;
	end
endmodule

// File: tb/pwm_timer_adc_trigger_gen_bench.sv
// Purpose: Self-checking bench of the trigger generator
// Assumes: Period 6, triangle sweeps
// Notes:   Trigger notes queued, checked by a monitor
`timescale 1ns/1ns
module pwm_timer_adc_trigger_gen_bench;
	localparam P = 6;
	reg         i_clk = 0;
	reg         i_rst_n = 0;
	reg  [7:0]  i_addr = 0;
	reg  [31:0] i_wdata = 0;
	reg         i_wr = 0;
	reg         i_rd = 0;
	reg  [15:0] cnt = 0;
	reg         stp = 0;
	reg         up = 0;
	reg         evc = 0;
	reg         saw = 0;
	reg  [5:0]  evs = 0;
	reg  [1:0]  chn = 0;
	reg  [3:0]  exp_st = 0;
	reg  [3:0]  exp_ir = 0;
	reg  [3:0]  en, f;
	reg  [2:0]  dc;
	reg  [15:0] ca, cb, ba, bb, sa, sb, nc;
	reg         ea, eb, nu;
	reg  [1:0]  q[$];
	integer     fails = 0;
	integer     total_checks = 0;
	integer     n_ev = 0;
	integer     j, t, pt, d;
	wire [31:0] o_rdata;
	wire [15:0] starts;
	wire [1:0]  pin;
	wire        o_trig_a, o_trig_b, o_irq;
	always #4 i_clk = ~i_clk;
	pwm_timer_adc_trigger_gen u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_period_counter(cnt),
		.i_period_setting(16'h0006), .i_count_step(stp), .i_count_up(up), .i_event_count(evc),
		.i_sawtooth(saw), .i_crest(evs[0]), .i_trough(evs[1]), .i_underflow(evs[2]),
		.i_overflow(evs[3]), .i_counter_clear(evs[4]), .i_cycle_end(evs[5]),
		.i_monitor_chain(chn), .o_trig_a(o_trig_a), .o_trig_b(o_trig_b),
		.o_trigger_monitor_pin(pin), .o_irq(o_irq));
	adc_event_model u_adc (.i_clk(i_clk), .i_trig_a(o_trig_a), .i_trig_b(o_trig_b), .o_starts(starts));
	task chk(input string nm, input [31:0] s, input [31:0] e);
	begin
		total_checks = total_checks + 1;
		if (s !== e)
		begin
			fails = fails + 1;
			$display("[ERR] %s exp %h seen %h", nm, e, s);
		end
	end
	endtask
	task print_verdict;
	begin
		if (fails == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask
	task wr(input [7:0] a, input [31:0] v);
	begin
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	end
	endtask
	task rd(input [7:0] a, input [31:0] e);
	begin
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 chk("rdata", o_rdata, e);
	end
	endtask
	task pulse(input [5:0] m);
	begin
		@(posedge i_clk);
		evs <= m;
		@(posedge i_clk);
		evs <= 6'h00;
	end
	endtask
	// Up interval 0..P-1, down interval P..1
	task sweep;
	begin
		for (j = 0; j < 2 * P; j = j + 1)
		begin
			@(posedge i_clk);
			// Expectation uses the value being driven now, not the one still standing
			nc = (j < P) ? j : 2 * P - j;
			nu = j < P;
			cnt <= nc;
			up <= nu;
			stp <= 1'b1;
			ea = !evc && nc == ca && en[{1'b0, !nu}];
			eb = !evc && nc == cb && en[{1'b1, !nu}];
			f = {eb & !nu, eb & nu, ea & !nu, ea & nu};
			exp_st = exp_st | f;
			exp_ir = exp_ir | f;
			if (ea | eb)
			begin
				q.push_back({ea, eb});
				n_ev = n_ev + 1;
			end
		end
		@(posedge i_clk);
		stp <= 1'b0;
	end
	endtask
	// Requests are compared against the oldest note
	always @(posedge i_clk)
		if (i_rst_n && (o_trig_a | o_trig_b) === 1'b1)
			chk("trig", {o_trig_a, o_trig_b}, q.size() ? q.pop_front() : 2'h0);
	initial
	begin
		#100000;
		fails = fails + 1;
		print_verdict;
	end
	initial
	begin
		t = $urandom(32'hE3178D25);
		repeat (5) @(posedge i_clk);
		i_rst_n <= 1'b1;
		for (t = 0; t < 8'h34; t = t + 4)
			rd(t, 0);
		for (t = 0; t < 12; t = t + 1)
		begin
			en = $urandom;
			ca = $urandom % (P + 1);
			cb = $urandom % (P + 1);
			wr(8'h00, en);
			wr(8'h18, ca);
			wr(8'h24, cb);
			sweep;
		end
		rd(8'h04, exp_st);
		wr(8'h04, 32'h00000005);
		exp_st = exp_st & 4'h5;
		rd(8'h04, exp_st);
		wr(8'h04, 32'h00000000);
		evc <= 1'b1;
		sweep;
		evc <= 1'b0;
		rd(8'h04, 0);
		rd(8'h08, exp_ir);
		exp_ir = 0;
		en = 1;
		ca = 2;
		wr(8'h00, en);
		wr(8'h18, ca);
		wr(8'h0C, 32'h00000002);
		sweep;
		chk("irq", o_irq, 0);
		wr(8'h0C, 32'h00000001);
		repeat (2) @(posedge i_clk);
		#1 chk("irq", o_irq, 1);
		rd(8'h08, exp_ir);
		repeat (2) @(posedge i_clk);
		#1 chk("irq", o_irq, 0);
		ca = 3;
		cb = 3;
		wr(8'h18, ca);
		wr(8'h24, cb);
		for (t = 0; t < 4; t = t + 1)
		begin
			wr(8'h14, t | 4);
			en = 15 ^ 1 << t;
			wr(8'h00, en);
			sweep;
			repeat (3) @(posedge i_clk);
			#1 chk("mon", pin, 0);
			en = 1 << t;
			wr(8'h00, en);
			sweep;
			repeat (8) @(posedge i_clk);
			#1 chk("mon", pin, 1);
			pulse(6'h20);
			repeat (2) @(posedge i_clk);
			#1 chk("mon", pin, 0);
		end
		chn <= 2'h2;
		repeat (2) @(posedge i_clk);
		#1 chk("chain", pin, 2);
		chn <= 2'h0;
		for (d = 0; d < 4; d = d + 1)
			for (t = 0; t < 4; t = t + 1)
				for (pt = 0; pt < 5; pt = pt + 1)
				begin
					dc = d * 2 + (d == 3);
					saw <= pt > 1;
					wr(8'h10, t << 6 | t << 4 | dc);
					{ca, cb} = $urandom;
					{ba, bb} = $urandom;
					{sa, sb} = $urandom;
					wr(8'h18, ca);
					wr(8'h1C, ba);
					wr(8'h20, sa);
					wr(8'h24, cb);
					wr(8'h28, bb);
					wr(8'h2C, sb);
					pulse(1 << pt);
					if (d < 3 && (pt > 1 ? pt - 1 == t : t[pt]))
					begin
						ca = ba;
						cb = bb;
						ba = dc[1] ? sa : ba;
						bb = dc[2] ? sb : bb;
					end
					rd(8'h18, ca);
					rd(8'h1C, ba);
					rd(8'h24, cb);
					rd(8'h28, bb);
				end
		repeat (10) @(posedge i_clk);
		chk("starts", starts, n_ev);
		chk("queue", q.size(), 0);
		print_verdict;
	end
endmodule
